//--- hw/mbc_params.svh
// Opcode fields, opcodes, lengths and cycle counts of the branch/control decoder
`ifndef MBC_PARAMS_SVH
`define MBC_PARAMS_SVH

// Short relative branch fields
`define MBC_KIND_MSB 2
`define MBC_KIND_LSB 0
`define MBC_DIR_BIT 3
`define MBC_SPAN_MSB 7
`define MBC_SPAN_LSB 4

// Short relative branch kinds (low three opcode bits, direction bit clear or set)
`define MBC_KIND_BR_NONZERO 3'h0
`define MBC_KIND_BR_NO_CARRY 3'h2
`define MBC_KIND_BR_ZERO 3'h4
`define MBC_KIND_BR_CARRY 3'h6

// Low nibble of the other groups
`define MBC_LOW_CALL 4'h1
`define MBC_LOW_ABS_JUMP 4'h9
`define MBC_LOW_BIT_TEST 4'h3
`define MBC_LOW_BIT_MOD 4'hb

// Bit groups: polarity bit and bit number bits (reversed order)
`define MBC_BIT_POL 4
`define MBC_BITNUM_B0 7
`define MBC_BITNUM_B1 6
`define MBC_BITNUM_B2 5

// Control opcodes
`define MBC_OPC_NO_OPERATION 8'h2d
`define MBC_OPC_RETURN 8'hcd
`define MBC_OPC_INT_RETURN 8'h4d
`define MBC_OPC_STOP 8'h6d
`define MBC_OPC_WAIT 8'hed

// Instruction lengths in bytes
`define MBC_LEN_SHORT 12'h001
`define MBC_LEN_TWO 12'h002
`define MBC_LEN_THREE 12'h003

// Cycle counts
`define MBC_CYC_SHORT_REL 3'h2
`define MBC_CYC_BIT_TEST 3'h5
`define MBC_CYC_BIT_MOD 3'h4
`define MBC_CYC_EXT 3'h4
`define MBC_CYC_CONTROL 3'h2

// Sub-cycles within multi-cycle instructions
`define MBC_CYC_OPERAND1 3'h1
`define MBC_CYC_OPERAND2 3'h2
`define MBC_CYC_DATA 3'h3

// Reset values
`define MBC_RST_PC 12'h000
`define MBC_RST_FLAGS 1'h0

`endif

//--- hw/mbc_pkg.sv
// Types shared by the branch/control decoder modules
package mbc_pkg;

  typedef enum logic [1:0]
  {
    MBC_ST_IDLE = 2'b00,
    MBC_ST_EXEC = 2'b01,
    MBC_ST_HALT = 2'b11
  } mbc_state_e;

  typedef enum logic [3:0]
  {
    MBC_OP_BR_NONZERO,
    MBC_OP_BR_NO_CARRY,
    MBC_OP_BR_ZERO,
    MBC_OP_BR_CARRY,
    MBC_OP_CALL,
    MBC_OP_ABS_JUMP,
    MBC_OP_BIT_TEST,
    MBC_OP_BIT_MOD,
    MBC_OP_NO_OPERATION,
    MBC_OP_RETURN,
    MBC_OP_INT_RETURN,
    MBC_OP_STOP,
    MBC_OP_WAIT,
    MBC_OP_OTHER
  } mbc_op_e;

  typedef logic [11:0] mbc_addr_t;

endpackage

//--- hw/mbc_dm_if.sv
// Data space port between the core and its data memory
`timescale 1ns/100ps
`default_nettype none

interface mbc_dm_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic we;
  logic [7:0] rdata;

  modport core (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface

`default_nettype wire

//--- hw/mbc_data_mem.sv
// Data space memory with registered read
`timescale 1ns/100ps
`default_nettype none

module mbc_data_mem #(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  mbc_dm_if.mem dm
);

  logic [7:0] mem_reg [DEPTH];

  always_ff @(posedge clk)
  begin
    if (dm.we)
    begin
      mem_reg[dm.addr] <= dm.wdata;
    end
  end

  // Read data is old contents on a write cycle
  always_ff @(posedge clk)
  begin
    dm.rdata <= mem_reg[dm.addr];
  end

endmodule // mbc_data_mem

`default_nettype wire

//--- hw/mbc_core.sv
// Branch, bit-handling, jump/call and control instruction sequencer
//
// Operation
// - Short branch taken only when flag condition holds
// - Short branch: 4-bit span, one byte, two cycles
// - Bit test branch: 8-bit displacement, three bytes, five
// - Bit test copies tested bit into carry
// - Three opcode bits select the data bit
// - Bit set/clear: two bytes, four cycles, flags kept
// - Bit test joins direct address with relative target
// - Control ops one byte, two cycles; interrupt_return restores flags
// - Watchdog option turns stop into wait
// - Jump/call: 12-bit target, two bytes, four cycles
// - Direction bit: 0 forward, 1 backward span
`include "mbc_params.svh"
`timescale 1ns/100ps
`default_nettype none

module mbc_core #(
  parameter int STACK_DEPTH = 6
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic RUN,
  input wire logic WDG_OPTION,
  input wire logic WAKE,
  input wire logic [7:0] PROG_DATA,
  output logic [11:0] PROG_ADDR,
  input wire logic FLAG_WR,
  input wire logic FLAG_C_IN,
  input wire logic FLAG_Z_IN,
  input wire logic NMF_C,
  input wire logic NMF_Z,
  input wire logic DMX_WE,
  input wire logic [7:0] DMX_ADDR,
  input wire logic [7:0] DMX_WDATA,
  output logic [7:0] DMX_RDATA,
  output logic FLAG_C,
  output logic FLAG_Z,
  output logic STOP_MODE,
  output logic WAIT_MODE,
  output logic INSTR_DONE,
  output logic UNKNOWN_OP
);

  localparam int SPW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
  localparam logic [SPW-1:0] SP_TOP = SPW'(STACK_DEPTH - 1);

  mbc_dm_if dm ();

  mbc_data_mem u_mem (
    .clk (CLK_SYS),
    .dm (dm.mem)
  );

  mbc_pkg::mbc_state_e state_reg;
  logic [2:0] cyc_reg;
  mbc_pkg::mbc_addr_t pc_reg;
  mbc_pkg::mbc_addr_t pc_next;
  mbc_pkg::mbc_addr_t prog_addr_reg;
  logic [7:0] opc_reg;
  logic [7:0] opr_reg;
  logic [7:0] disp_reg;
  logic [7:0] dm_addr_reg;
  logic tbit_reg;
  logic carry_reg;
  logic zero_reg;
  logic stop_reg;
  logic wait_reg;
  logic done_reg;
  logic unknown_reg;
  mbc_pkg::mbc_addr_t stk_reg [STACK_DEPTH];
  logic [SPW-1:0] sp_reg;
  logic [SPW-1:0] sp_prev;
  logic [7:0] cur_op;
  mbc_pkg::mbc_op_e cls;
  logic last;
  logic [2:0] bit_num;
  logic [7:0] bit_mask;
  logic taken;

  // Opcode classification
  function automatic mbc_pkg::mbc_op_e classify(input logic [7:0] op);
    classify = mbc_pkg::MBC_OP_OTHER;
    if (op == `MBC_OPC_NO_OPERATION)
      classify = mbc_pkg::MBC_OP_NO_OPERATION;
    else if (op == `MBC_OPC_RETURN)
      classify = mbc_pkg::MBC_OP_RETURN;
    else if (op == `MBC_OPC_INT_RETURN)
      classify = mbc_pkg::MBC_OP_INT_RETURN;
    else if (op == `MBC_OPC_STOP)
      classify = mbc_pkg::MBC_OP_STOP;
    else if (op == `MBC_OPC_WAIT)
      classify = mbc_pkg::MBC_OP_WAIT;
    else if (op[3:0] == `MBC_LOW_CALL)
      classify = mbc_pkg::MBC_OP_CALL;
    else if (op[3:0] == `MBC_LOW_ABS_JUMP)
      classify = mbc_pkg::MBC_OP_ABS_JUMP;
    else if (op[3:0] == `MBC_LOW_BIT_TEST)
      classify = mbc_pkg::MBC_OP_BIT_TEST;
    else if (op[3:0] == `MBC_LOW_BIT_MOD)
      classify = mbc_pkg::MBC_OP_BIT_MOD;
    else
    begin
      case (op[`MBC_KIND_MSB:`MBC_KIND_LSB])
        `MBC_KIND_BR_NONZERO: classify = mbc_pkg::MBC_OP_BR_NONZERO;
        `MBC_KIND_BR_NO_CARRY: classify = mbc_pkg::MBC_OP_BR_NO_CARRY;
        `MBC_KIND_BR_ZERO: classify = mbc_pkg::MBC_OP_BR_ZERO;
        `MBC_KIND_BR_CARRY: classify = mbc_pkg::MBC_OP_BR_CARRY;
        default: classify = mbc_pkg::MBC_OP_OTHER;
      endcase
    end
  endfunction

  // Cycles taken by each class
  function automatic logic [2:0] op_cycles(input mbc_pkg::mbc_op_e c);
    case (c)
      mbc_pkg::MBC_OP_BR_NONZERO,
      mbc_pkg::MBC_OP_BR_NO_CARRY,
      mbc_pkg::MBC_OP_BR_ZERO,
      mbc_pkg::MBC_OP_BR_CARRY: op_cycles = `MBC_CYC_SHORT_REL;
      mbc_pkg::MBC_OP_BIT_TEST: op_cycles = `MBC_CYC_BIT_TEST;
      mbc_pkg::MBC_OP_BIT_MOD: op_cycles = `MBC_CYC_BIT_MOD;
      mbc_pkg::MBC_OP_CALL,
      mbc_pkg::MBC_OP_ABS_JUMP: op_cycles = `MBC_CYC_EXT;
      default: op_cycles = `MBC_CYC_CONTROL;
    endcase
  endfunction

  assign cur_op = (cyc_reg == 3'h0) ? PROG_DATA : opc_reg;
  assign cls = classify(cur_op);
  assign last = (state_reg == mbc_pkg::MBC_ST_EXEC) && (cyc_reg == op_cycles(cls) - 3'h1);
  assign bit_num = {opc_reg[`MBC_BITNUM_B2], opc_reg[`MBC_BITNUM_B1],
                    opc_reg[`MBC_BITNUM_B0]};
  assign bit_mask = 8'h01 << bit_num;
  assign sp_prev = (sp_reg == '0) ? SP_TOP : sp_reg - SPW'(1);

  // Branch condition
  always_comb
  begin
    case (cls)
      mbc_pkg::MBC_OP_BR_NONZERO: taken = !zero_reg;
      mbc_pkg::MBC_OP_BR_NO_CARRY: taken = !carry_reg;
      mbc_pkg::MBC_OP_BR_ZERO: taken = zero_reg;
      mbc_pkg::MBC_OP_BR_CARRY: taken = carry_reg;
      mbc_pkg::MBC_OP_BIT_TEST: taken = (tbit_reg == opc_reg[`MBC_BIT_POL]);
      default: taken = 1'b0;
    endcase
  end

  // Address of the next instruction
  always_comb
  begin
    pc_next = pc_reg + `MBC_LEN_SHORT;
    case (cls)
      mbc_pkg::MBC_OP_BR_NONZERO,
      mbc_pkg::MBC_OP_BR_NO_CARRY,
      mbc_pkg::MBC_OP_BR_ZERO,
      mbc_pkg::MBC_OP_BR_CARRY:
      begin
        if (taken && opc_reg[`MBC_DIR_BIT])
          pc_next = pc_reg - {8'h00, opc_reg[`MBC_SPAN_MSB:`MBC_SPAN_LSB]};
        else if (taken)
          pc_next = pc_reg + `MBC_LEN_SHORT
                    + {8'h00, opc_reg[`MBC_SPAN_MSB:`MBC_SPAN_LSB]};
      end
      mbc_pkg::MBC_OP_BIT_TEST:
      begin
        if (taken)
          pc_next = pc_reg + `MBC_LEN_TWO + {{4{disp_reg[7]}}, disp_reg};
        else
          pc_next = pc_reg + `MBC_LEN_THREE;
      end
      mbc_pkg::MBC_OP_BIT_MOD: pc_next = pc_reg + `MBC_LEN_TWO;
      mbc_pkg::MBC_OP_CALL,
      mbc_pkg::MBC_OP_ABS_JUMP: pc_next = {opc_reg[7:4], opr_reg};
      mbc_pkg::MBC_OP_RETURN,
      mbc_pkg::MBC_OP_INT_RETURN: pc_next = stk_reg[sp_prev];
      default: pc_next = pc_reg + `MBC_LEN_SHORT;
    endcase
  end

  // Data memory port: outside access only while idle
  always_comb
  begin
    if (state_reg == mbc_pkg::MBC_ST_IDLE)
    begin
      dm.addr = DMX_ADDR;
      dm.we = DMX_WE;
      dm.wdata = DMX_WDATA;
    end
    else
    begin
      dm.addr = dm_addr_reg;
      dm.we = (state_reg == mbc_pkg::MBC_ST_EXEC) && (cls == mbc_pkg::MBC_OP_BIT_MOD)
              && (cyc_reg == `MBC_CYC_DATA);
      dm.wdata = opc_reg[`MBC_BIT_POL] ? (dm.rdata | bit_mask)
                 : (dm.rdata & ~bit_mask);
    end
  end

  // Sequencer state
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state_reg <= mbc_pkg::MBC_ST_IDLE;
      cyc_reg <= 3'h0;
    end
    else
    begin
      case (state_reg)
        mbc_pkg::MBC_ST_IDLE:
          if (RUN)
            state_reg <= mbc_pkg::MBC_ST_EXEC;
        mbc_pkg::MBC_ST_EXEC:
        begin
          cyc_reg <= last ? 3'h0 : cyc_reg + 3'h1;
          if (last && (cls == mbc_pkg::MBC_OP_STOP || cls == mbc_pkg::MBC_OP_WAIT))
            state_reg <= mbc_pkg::MBC_ST_HALT;
          else if (last && !RUN)
            state_reg <= mbc_pkg::MBC_ST_IDLE;
        end
        mbc_pkg::MBC_ST_HALT:
          if (WAKE)
            state_reg <= mbc_pkg::MBC_ST_EXEC;
        default: state_reg <= mbc_pkg::MBC_ST_IDLE;
      endcase
    end
  end

  // Program counter, fetch address and operand capture
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      pc_reg <= `MBC_RST_PC;
      prog_addr_reg <= `MBC_RST_PC;
      opc_reg <= 8'h00;
      opr_reg <= 8'h00;
      disp_reg <= 8'h00;
      dm_addr_reg <= 8'h00;
    end
    else if (state_reg == mbc_pkg::MBC_ST_EXEC)
    begin
      if (cyc_reg == 3'h0)
        opc_reg <= PROG_DATA;
      if (cyc_reg == `MBC_CYC_OPERAND1)
      begin
        opr_reg <= PROG_DATA;
        dm_addr_reg <= PROG_DATA;
      end
      if (cyc_reg == `MBC_CYC_OPERAND2)
        disp_reg <= PROG_DATA;
      if (last)
      begin
        pc_reg <= pc_next;
        prog_addr_reg <= pc_next;
      end
      else
        prog_addr_reg <= pc_reg + {9'h000, cyc_reg} + `MBC_LEN_SHORT;
    end
  end

  // Return stack
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      sp_reg <= '0;
    else if (last && cls == mbc_pkg::MBC_OP_CALL)
    begin
      stk_reg[sp_reg] <= pc_reg + `MBC_LEN_TWO;
      sp_reg <= (sp_reg == SP_TOP) ? '0 : sp_reg + SPW'(1);
    end
    else if (last && (cls == mbc_pkg::MBC_OP_RETURN || cls == mbc_pkg::MBC_OP_INT_RETURN))
      sp_reg <= sp_prev;
  end

  // Flags; core updates win over the outside load
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      carry_reg <= `MBC_RST_FLAGS;
      zero_reg <= `MBC_RST_FLAGS;
      tbit_reg <= 1'b0;
    end
    else if (state_reg == mbc_pkg::MBC_ST_EXEC && cls == mbc_pkg::MBC_OP_BIT_TEST
             && cyc_reg == `MBC_CYC_DATA)
    begin
      tbit_reg <= dm.rdata[bit_num];
      carry_reg <= dm.rdata[bit_num];
    end
    else if (last && cls == mbc_pkg::MBC_OP_INT_RETURN)
    begin
      carry_reg <= NMF_C;
      zero_reg <= NMF_Z;
    end
    else if (FLAG_WR)
    begin
      carry_reg <= FLAG_C_IN;
      zero_reg <= FLAG_Z_IN;
    end
  end

  // Power-saving mode outputs
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      stop_reg <= 1'b0;
      wait_reg <= 1'b0;
    end
    else if (last && cls == mbc_pkg::MBC_OP_STOP)
    begin
      stop_reg <= !WDG_OPTION;
      wait_reg <= WDG_OPTION;
    end
    else if (last && cls == mbc_pkg::MBC_OP_WAIT)
      wait_reg <= 1'b1;
    else if (state_reg == mbc_pkg::MBC_ST_HALT && WAKE)
    begin
      stop_reg <= 1'b0;
      wait_reg <= 1'b0;
    end
  end

  // Completion and unknown-opcode pulses
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      done_reg <= 1'b0;
      unknown_reg <= 1'b0;
    end
    else
    begin
      done_reg <= last;
      unknown_reg <= last && (cls == mbc_pkg::MBC_OP_OTHER);
    end
  end

  assign PROG_ADDR = prog_addr_reg;
  assign DMX_RDATA = dm.rdata;
  assign FLAG_C = carry_reg;
  assign FLAG_Z = zero_reg;
  assign STOP_MODE = stop_reg;
  assign WAIT_MODE = wait_reg;
  assign INSTR_DONE = done_reg;
  assign UNKNOWN_OP = unknown_reg;

endmodule // mbc_core

`default_nettype wire

//--- dv/mbc_core_properties.sv
// Port-level properties of the branch/control core
`timescale 1ns/100ps
`default_nettype none

module mbc_core_properties (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic RUN,
  input wire logic WDG_OPTION,
  input wire logic WAKE,
  input wire logic FLAG_WR,
  input wire logic [11:0] PROG_ADDR,
  input wire logic FLAG_C,
  input wire logic FLAG_Z,
  input wire logic STOP_MODE,
  input wire logic WAIT_MODE,
  input wire logic INSTR_DONE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence s_halt_wake;
    (STOP_MODE || WAIT_MODE) && WAKE;
  endsequence

  sequence s_running;
    !STOP_MODE && !WAIT_MODE;
  endsequence

  // Flag moves not caused by the load port; first edge after reset excluded
  sequence s_zero_moved;
    $changed(FLAG_Z) && !$past(FLAG_WR) && !$past(RST);
  endsequence

  sequence s_carry_moved;
    $changed(FLAG_C) && !$past(FLAG_WR) && !$past(RST);
  endsequence

  // Instruction finished with run dropped at its last edge
  sequence s_idle_end;
    INSTR_DONE && !RUN && !$past(RUN);
  endsequence

  a_done_gap: assert property (INSTR_DONE |=> !INSTR_DONE)
    else $error("completion pulse lasted more than one cycle");
  a_modes_excl: assert property (!(STOP_MODE && WAIT_MODE))
    else $error("stop and wait modes high together");
  a_stop_option: assert property ($rose(STOP_MODE) |-> !$past(WDG_OPTION))
    else $error("stop mode entered with watchdog option set");
  a_wake_resume: assert property (s_halt_wake |=> s_running)
    else $error("halt mode kept after wake");
  a_halt_hold: assert property ((STOP_MODE || WAIT_MODE) && !WAKE |=> $stable(PROG_ADDR))
    else $error("fetch address moved while halted");
  a_zero_source: assert property (s_zero_moved |-> INSTR_DONE)
    else $error("zero flag changed outside load or interrupt return");
  a_carry_source: assert property (s_carry_moved |-> ##[0:2] INSTR_DONE)
    else $error("carry changed outside load, bit test or interrupt return");
  a_idle_hold: assert property ((s_idle_end and s_running) |=> $stable(PROG_ADDR))
    else $error("fetch address moved after stopping");
endmodule // mbc_core_properties

bind mbc_core mbc_core_properties u_props (
  .CLK_SYS(CLK_SYS),
  .RST(RST),
  .RUN(RUN),
  .WDG_OPTION(WDG_OPTION),
  .WAKE(WAKE),
  .FLAG_WR(FLAG_WR),
  .PROG_ADDR(PROG_ADDR),
  .FLAG_C(FLAG_C),
  .FLAG_Z(FLAG_Z),
  .STOP_MODE(STOP_MODE),
  .WAIT_MODE(WAIT_MODE),
  .INSTR_DONE(INSTR_DONE)
);

`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the branch/control core
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam logic [7:0] PAT = 8'ha5;
  logic clk = 1'b0, rst = 1'b1, run = 1'b0, wdg = 1'b0, wake = 1'b0;
  logic fwr = 1'b0, fc = 1'b0, fz = 1'b0, nc = 1'b0, nz = 1'b0, dwe = 1'b0;
  logic [7:0] dadr = 8'h00, dwd = 8'h00, drd, pdata;
  logic [11:0] paddr;
  logic oc, oz, stp, wt, done, unk;
  logic [7:0] rom [0:4095];
  int n_fail = 0, total_checks = 0, cyc = 0;

  always #20 clk = ~clk;
  assign pdata = rom[paddr];

  mbc_core u_dut (
    .CLK_SYS(clk), .RST(rst), .RUN(run), .WDG_OPTION(wdg), .WAKE(wake),
    .PROG_DATA(pdata), .PROG_ADDR(paddr), .FLAG_WR(fwr), .FLAG_C_IN(fc),
    .FLAG_Z_IN(fz), .NMF_C(nc), .NMF_Z(nz), .DMX_WE(dwe), .DMX_ADDR(dadr),
    .DMX_WDATA(dwd), .DMX_RDATA(drd), .FLAG_C(oc), .FLAG_Z(oz),
    .STOP_MODE(stp), .WAIT_MODE(wt), .INSTR_DONE(done), .UNKNOWN_OP(unk)
  );

  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rstp();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic setf(input logic c, input logic z);
    @(posedge clk);
    fwr <= 1'b1;
    fc <= c;
    fz <= z;
    @(posedge clk);
    fwr <= 1'b0;
  endtask

  task automatic wrmem(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    dwe <= 1'b1;
    dadr <= a;
    dwd <= d;
    @(posedge clk);
    dwe <= 1'b0;
  endtask

  // One instruction placed at a, run with RUN dropped at once
  task automatic run1(input logic [11:0] a, input logic [7:0] op, input logic [7:0] b2,
    input logic [7:0] b3, input logic [11:0] ep, input int ec);
    int k;
    rom[a] = op;
    rom[a + 12'h001] = b2;
    rom[a + 12'h002] = b3;
    @(posedge clk);
    run <= 1'b1;
    @(posedge clk);
    run <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (done !== 1'b1 && k < 20);
    chk(12'(k), 12'(ec));
    chk(paddr, ep);
  endtask

  task automatic t_short();
    logic [2:0] kd;
    logic f;
    logic [11:0] e;
    for (int i = 0; i < 16; i++)
    begin
      f = i[0];
      kd = {i[2:1], 1'b0};
      e = (f != kd[2]) ? 12'h001 : (i[3] ? 12'hff1 : 12'h010);
      rstp();
      setf(f, f);
      run1(12'h000, {4'hf, i[3], kd}, 8'h00, 8'h00, e, 2);
      chk(12'({oc, oz}), 12'({f, f}));
    end
  endtask

  task automatic t_bits();
    logic [2:0] b;
    logic p;
    logic [7:0] d;
    logic [11:0] e;
    for (int i = 0; i < 16; i++)
    begin
      b = i[2:0];
      p = i[3];
      d = b[0] ? 8'h7f : 8'h80;
      e = (PAT[b] == p) ? 12'h002 + {{4{d[7]}}, d} : 12'h003;
      rstp();
      wrmem(8'h40, PAT);
      setf(!PAT[b], 1'b1);
      run1(12'h000, {b[0], b[1], b[2], p, 4'h3}, 8'h40, d, e, 5);
      chk(12'({oc, oz}), 12'({PAT[b], 1'b1}));
      rstp();
      setf(1'b1, 1'b0);
      run1(12'h000, {b[0], b[1], b[2], p, 4'hb}, 8'h40, 8'h00, 12'h002, 4);
      @(posedge clk);
      dadr <= 8'h40;
      @(posedge clk);
      #1;
      e = 12'(p ? (PAT | (8'h01 << b)) : (PAT & ~(8'h01 << b)));
      chk(12'(drd), e);
      chk(12'({oc, oz}), 12'h002);
    end
  endtask

  task automatic t_flow();
    rstp();
    setf(1'b1, 1'b1);
    run1(12'h000, 8'hf9, 8'hfe, 8'h00, 12'hffe, 4);
    chk(12'({oc, oz}), 12'h003);
    run1(12'hffe, 8'h51, 8'ha3, 8'h00, 12'h5a3, 4);
    run1(12'h5a3, 8'hcd, 8'h00, 8'h00, 12'h000, 2);
    setf(1'b0, 1'b1);
    nc <= 1'b1;
    run1(12'h000, 8'h01, 8'h10, 8'h00, 12'h010, 4);
    run1(12'h010, 8'h4d, 8'h00, 8'h00, 12'h002, 2);
    chk(12'({oc, oz}), 12'h002);
    run1(12'h002, 8'h2d, 8'h00, 8'h00, 12'h003, 2);
    chk(12'({oc, oz}), 12'h002);
    chk(12'(unk), 12'h000);
    run1(12'h003, 8'h05, 8'h00, 8'h00, 12'h004, 2);
    chk(12'(unk), 12'h001);
  endtask

  task automatic t_halt();
    for (int i = 0; i < 4; i++)
    begin
      rstp();
      wdg <= i[0];
      run1(12'h000, i[1] ? 8'hed : 8'h6d, 8'h00, 8'h00, 12'h001, 2);
      @(posedge clk);
      #1;
      chk(12'({stp, wt}), (!i[1] && !i[0]) ? 12'h002 : 12'h001);
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      #1;
      chk(12'({stp, wt}), 12'h000);
    end
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      results();
    end
  end

  initial
  begin
    for (int i = 0; i < 4096; i++)
      rom[i] = 8'h2d;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_short();
    t_bits();
    t_flow();
    t_halt();
    results();
  end
endmodule // tb_top

`default_nettype wire
